// file: verilog/eai_regs.svh
`ifndef EAI_REGS_SVH
`define EAI_REGS_SVH
`define EAI_OFF_CTRL      8'h00
`define EAI_OFF_EXT       8'h04
`define EAI_OFF_SW        8'h08
`define EAI_OFF_PROG      8'h0c
`define EAI_OFF_MSRC      8'h10
`define EAI_OFF_MDST      8'h14
`define EAI_OFF_EA_ADDR   8'h18
`define EAI_OFF_EA_ADDR2  8'h1c
`define EAI_OFF_STAT      8'h20
`define EAI_OFF_USER_STK  8'h24
`define EAI_OFF_SUPER_STK 8'h28
`define EAI_WIN_DATA      3'h2
`define EAI_WIN_ADDR      3'h3
`define EAI_SW_S          13
`define EAI_SW_X          4
`define EAI_SW_RESET      16'h2000
`define EAI_STACK_CELL    32'h0000_0004
`endif

// file: verilog/eai_pkg.sv
package eai_pkg;
	typedef enum logic [1:0] {EAI_SZ_BYTE, EAI_SZ_WORD, EAI_SZ_LONG, EAI_SZ_NONE} eai_size_type;
	typedef enum logic [5:0] {
		EAI_OP_MOVE, EAI_OP_SWAP, EAI_OP_EXCHANGE, EAI_OP_FRAME_LINK, EAI_OP_FRAME_RELEASE,
		EAI_OP_QUICK_LOAD, EAI_OP_ADDRESS_LOAD, EAI_OP_ADDRESS_PUSH, EAI_OP_ADD, EAI_OP_SUB,
		EAI_OP_EXTENDED_SUM, EAI_OP_EXTENDED_DIFF, EAI_OP_EXTENDED_COMPLEMENT, EAI_OP_NEGATE,
		EAI_OP_ZERO_WRITE, EAI_OP_SIGN_WIDEN, EAI_OP_ZERO_TEST, EAI_OP_TEST_SET, EAI_OP_COMPARE,
		EAI_OP_SIGNED_PRODUCT, EAI_OP_UNSIGNED_PRODUCT, EAI_OP_SIGNED_QUOTIENT,
		EAI_OP_UNSIGNED_QUOTIENT, EAI_OP_IMMEDIATE_AND, EAI_OP_IMMEDIATE_OR, EAI_OP_IMMEDIATE_XOR,
		EAI_OP_MOVE_TO_SW, EAI_OP_MOVE_FROM_SW
	} eai_op_type;
	typedef enum logic [1:0] {EAI_DST_DATA, EAI_DST_ADDR, EAI_DST_MEM, EAI_DST_NONE} eai_dst_type;
	// launch word written to the control register
	typedef struct packed {
		logic [10:0]  unused;
		logic         ccr_only;
		logic         sw_select;
		eai_dst_type  dst_kind;
		logic [2:0]   dst_reg;
		logic [2:0]   ea_mode;
		logic [2:0]   ea_reg;
		eai_size_type size;
		eai_op_type   op;
	} eai_ctl_type;
	// condition flags in status word order
	typedef struct packed {
		logic x;
		logic n;
		logic z;
		logic v;
		logic c;
	} eai_flags_type;
endpackage : eai_pkg

// file: verilog/eai_exec_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "eai_regs.svh"
module eai_exec_unit (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// classic wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// core state
	output logic                  supervisor_o,
	output logic                  fault_o,
	output eai_pkg::eai_flags_type flags_o
);
	import eai_pkg::*;

	function automatic logic [31:0] zx(input eai_size_type s, input logic [31:0] v);
		case (s)
			EAI_SZ_BYTE: zx = {24'h0, v[7:0]};
			EAI_SZ_WORD: zx = {16'h0, v[15:0]};
			default:     zx = v;
		endcase
	endfunction : zx

	function automatic logic top(input eai_size_type s, input logic [31:0] v);
		case (s)
			EAI_SZ_BYTE: top = v[7];
			EAI_SZ_WORD: top = v[15];
			default:     top = v[31];
		endcase
	endfunction : top

	function automatic logic cout(input eai_size_type s, input logic [32:0] v);
		case (s)
			EAI_SZ_BYTE: cout = v[8];
			EAI_SZ_WORD: cout = v[16];
			default:     cout = v[32];
		endcase
	endfunction : cout

	// merge a sized result into the low part of a wider register
	function automatic logic [31:0] fit(input eai_size_type s, input logic [31:0] o, input logic [31:0] v);
		case (s)
			EAI_SZ_BYTE: fit = {o[31:8], v[7:0]};
			EAI_SZ_WORD: fit = {o[31:16], v[15:0]};
			default:     fit = v;
		endcase
	endfunction : fit

	function automatic logic [31:0] bmerge(input logic [3:0] sel, input logic [31:0] o, input logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			bmerge[i*8 +: 8] = sel[i] ? v[i*8 +: 8] : o[i*8 +: 8];
		end
	endfunction : bmerge

	function automatic logic [31:0] sx16(input logic [15:0] v);
		sx16 = {{16{v[15]}}, v};
	endfunction : sx16

	function automatic logic [31:0] sx8(input logic [7:0] v);
		sx8 = {{24{v[7]}}, v};
	endfunction : sx8

	// byte steps through the stack register stay word aligned
	function automatic logic [31:0] stepf(input eai_size_type s, input logic [2:0] r);
		case (s)
			EAI_SZ_LONG: stepf = 32'h0000_0004;
			EAI_SZ_WORD: stepf = 32'h0000_0002;
			default:     stepf = (r == 3'h7) ? 32'h0000_0002 : 32'h0000_0001;
		endcase
	endfunction : stepf

	logic [31:0]   dreg_q [8];
	logic [31:0]   dreg_d [8];
	logic [31:0]   areg_q [7];
	logic [31:0]   av     [8];
	logic [31:0]   av_d   [8];
	logic [31:0]   user_stk_q, super_stk_q;
	logic [31:0]   prog_ctr_q, prog_ctr_d, msrc_q, msrc_d, mdst_q, mdst_d;
	logic [31:0]   ea_addr_q, ea_addr_d, ea_addr2_q, ea_addr2_d;
	logic [15:0]   sw_q, sw_d, ext0_q, ext1_q;
	logic [31:0]   ext_d;
	eai_ctl_type   ctl_q, ctl_d, c;
	logic          fault_q, fault_d, divz_q, divz_d, ack_q;
	logic [31:0]   rdat_q, rdat;
	logic          req, wr, go, illegal, pair, single, uses_ea, is_add, is_sub, fl_en, x_en;
	logic          wb_dst, wb_ea, sw_op, ovf;
	logic [31:0]   act_stk, step, idx, ea, src, dst_val, a_op, b_op, res, quo, rem;
	logic [32:0]   addv, subv;
	logic          xin;
	eai_size_type  asz, wsz, fsz;
	eai_flags_type fl;

	assign req          = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr           = req & wb_we_i;
	assign go           = wr & (wb_adr_i == `EAI_OFF_CTRL) & (wb_sel_i == 4'hf);
	assign c            = eai_ctl_type'(wb_dat_i);
	assign wb_ack_o     = ack_q;
	assign wb_dat_o     = rdat_q;
	assign supervisor_o = sw_q[`EAI_SW_S];
	assign fault_o      = fault_q;
	assign flags_o      = eai_flags_type'(sw_q[4:0]);
	// the other stack is read only at its own offset: only the active one shows as register seven
	assign act_stk      = sw_q[`EAI_SW_S] ? super_stk_q : user_stk_q;

	// address register view, seven being the active stack
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			av[i] = areg_q[i];
		end
		av[7] = act_stk;
	end

	// operand addressing from mode and register fields
	always_comb begin
		step = stepf(c.size, c.ea_reg);
		idx  = ext0_q[15] ? av[ext0_q[14:12]] : dreg_q[ext0_q[14:12]];
		if (!ext0_q[11]) begin
			idx = sx16(idx[15:0]);
		end
		ea  = 32'h0;
		src = msrc_q; // memory modes read the operand software staged
		case (c.ea_mode)
			3'h0: src = dreg_q[c.ea_reg];
			3'h1: src = av[c.ea_reg];
			3'h2: ea = av[c.ea_reg];
			3'h3: ea = av[c.ea_reg];
			3'h4: ea = av[c.ea_reg] - step;
			3'h5: ea = av[c.ea_reg] + sx16(ext0_q);
			3'h6: ea = av[c.ea_reg] + sx8(ext0_q[7:0]) + idx;
			default: begin
				case (c.ea_reg)
					3'h0: ea = sx16(ext0_q);
					3'h1: ea = {ext0_q, ext1_q};
					3'h2: ea = prog_ctr_q + sx16(ext0_q);
					3'h3: ea = prog_ctr_q + sx8(ext0_q[7:0]) + idx;
					3'h4: src = (c.size == EAI_SZ_LONG) ? {ext0_q, ext1_q} : zx(c.size, {16'h0, ext0_q});
					default: src = 32'h0;
				endcase
			end
		endcase
	end

	// operation class and refusal of illegal launches
	always_comb begin
		sw_op   = c.op inside {EAI_OP_IMMEDIATE_AND, EAI_OP_IMMEDIATE_OR, EAI_OP_IMMEDIATE_XOR,
		                       EAI_OP_MOVE_TO_SW, EAI_OP_MOVE_FROM_SW};
		single  = c.op inside {EAI_OP_EXTENDED_COMPLEMENT, EAI_OP_NEGATE, EAI_OP_ZERO_WRITE,
		                       EAI_OP_ZERO_TEST, EAI_OP_TEST_SET, EAI_OP_MOVE_FROM_SW};
		uses_ea = !(c.op inside {EAI_OP_SWAP, EAI_OP_EXCHANGE, EAI_OP_FRAME_LINK, EAI_OP_FRAME_RELEASE,
		                         EAI_OP_QUICK_LOAD, EAI_OP_SIGN_WIDEN, EAI_OP_IMMEDIATE_AND,
		                         EAI_OP_IMMEDIATE_OR, EAI_OP_IMMEDIATE_XOR});
		pair    = (c.dst_kind == EAI_DST_MEM) &&
		          (c.op inside {EAI_OP_EXTENDED_SUM, EAI_OP_EXTENDED_DIFF, EAI_OP_COMPARE});
		illegal = 1'b0;
		if (uses_ea && c.ea_mode == 3'h7 && c.ea_reg > 3'h4) illegal = 1'b1;
		if (sw_op != c.sw_select) illegal = 1'b1;
		if (c.dst_kind == EAI_DST_ADDR && c.size == EAI_SZ_BYTE) illegal = 1'b1;
		if (c.dst_kind == EAI_DST_ADDR && !(c.op inside {EAI_OP_MOVE, EAI_OP_ADD, EAI_OP_SUB,
		    EAI_OP_COMPARE, EAI_OP_EXCHANGE})) illegal = 1'b1;
		if (pair && c.op != EAI_OP_COMPARE && c.ea_mode != 3'h4) illegal = 1'b1;
		if (pair && c.op == EAI_OP_COMPARE && c.ea_mode != 3'h3) illegal = 1'b1;
		if (single && c.op != EAI_OP_ZERO_TEST && (c.ea_mode == 3'h1 || c.ea_mode == 3'h7)) illegal = 1'b1;
		if (c.op inside {EAI_OP_ADDRESS_LOAD, EAI_OP_ADDRESS_PUSH} &&
		    (c.ea_mode inside {3'h0, 3'h1, 3'h3, 3'h4} || (c.ea_mode == 3'h7 && c.ea_reg == 3'h4))) illegal = 1'b1;
		if (c.op inside {EAI_OP_SIGNED_QUOTIENT, EAI_OP_UNSIGNED_QUOTIENT} && src[15:0] == 16'h0) illegal = 1'b1;
	end

	// arithmetic core: operands, sums and flags at the operation's size
	always_comb begin
		asz     = (c.dst_kind == EAI_DST_ADDR) ? EAI_SZ_LONG : c.size; // address forms work on 32 bits
		wsz     = asz;
		fsz     = asz;
		dst_val = (c.dst_kind == EAI_DST_ADDR) ? av[c.dst_reg] : (pair ? mdst_q : dreg_q[c.dst_reg]);
		b_op    = (c.dst_kind == EAI_DST_ADDR && c.size == EAI_SZ_WORD) ? sx16(src[15:0]) : src;
		a_op    = single ? 32'h0 : dst_val;
		if (c.dst_kind == EAI_DST_MEM && !pair && !single) begin
			a_op = src; // memory destination: the located operand is the minuend
			b_op = dreg_q[c.dst_reg];
		end
		xin  = (c.op inside {EAI_OP_EXTENDED_SUM, EAI_OP_EXTENDED_DIFF, EAI_OP_EXTENDED_COMPLEMENT}) &
		       sw_q[`EAI_SW_X];
		addv = {1'b0, zx(asz, a_op)} + {1'b0, zx(asz, b_op)} + {32'h0, xin};
		subv = {1'b0, zx(asz, a_op)} - {1'b0, zx(asz, b_op)} - {32'h0, xin};
		if (c.op == EAI_OP_SIGNED_QUOTIENT) begin
			quo = 32'($signed(dreg_q[c.dst_reg]) / $signed(sx16(src[15:0])));
			rem = 32'($signed(dreg_q[c.dst_reg]) % $signed(sx16(src[15:0])));
			ovf = (quo[31:15] != {17{1'b0}}) && (quo[31:15] != {17{1'b1}});
		end else begin
			quo = dreg_q[c.dst_reg] / {16'h0, (src[15:0] == 16'h0) ? 16'h1 : src[15:0]};
			rem = dreg_q[c.dst_reg] % {16'h0, (src[15:0] == 16'h0) ? 16'h1 : src[15:0]};
			ovf = quo[31:16] != 16'h0;
		end
		fl     = eai_flags_type'(sw_q[4:0]);
		res    = b_op;
		is_add = 1'b0;
		is_sub = 1'b0;
		fl_en  = 1'b1;
		x_en   = 1'b0;
		wb_dst = 1'b0;
		wb_ea  = 1'b0;
		case (c.op)
			EAI_OP_MOVE: wb_dst = 1'b1;
			EAI_OP_ADD, EAI_OP_EXTENDED_SUM: begin
				res    = addv[31:0];
				is_add = 1'b1;
				x_en   = 1'b1;
				wb_dst = 1'b1;
			end
			EAI_OP_SUB, EAI_OP_EXTENDED_DIFF: begin
				res    = subv[31:0];
				is_sub = 1'b1;
				x_en   = 1'b1;
				wb_dst = 1'b1;
			end
			EAI_OP_NEGATE, EAI_OP_EXTENDED_COMPLEMENT: begin
				res    = subv[31:0]; // zero minus the operand, and minus X for the extended complement
				is_sub = 1'b1;
				x_en   = 1'b1;
				wb_ea  = 1'b1;
			end
			EAI_OP_COMPARE: begin
				res    = subv[31:0]; // flags only
				is_sub = 1'b1;
			end
			EAI_OP_ZERO_WRITE: begin
				res   = 32'h0;
				wb_ea = 1'b1;
			end
			EAI_OP_ZERO_TEST: res = b_op;
			EAI_OP_TEST_SET: begin
				fsz   = EAI_SZ_BYTE;
				wsz   = EAI_SZ_BYTE;
				res   = b_op | 32'h0000_0080; // flags from the value before bit 7 is set
				wb_ea = 1'b1;
			end
			EAI_OP_QUICK_LOAD: begin
				wsz    = EAI_SZ_LONG;
				fsz    = EAI_SZ_LONG;
				res    = sx8(ext0_q[7:0]);
				wb_dst = 1'b1;
			end
			EAI_OP_SIGN_WIDEN: begin
				res    = (c.size == EAI_SZ_LONG) ? sx16(dst_val[15:0]) : sx8(dst_val[7:0]);
				wsz    = (c.size == EAI_SZ_LONG) ? EAI_SZ_LONG : EAI_SZ_WORD;
				fsz    = wsz;
				wb_dst = 1'b1;
			end
			EAI_OP_SWAP: begin
				wsz    = EAI_SZ_LONG;
				fsz    = EAI_SZ_LONG;
				res    = {dst_val[15:0], dst_val[31:16]};
				wb_dst = 1'b1;
			end
			EAI_OP_SIGNED_PRODUCT, EAI_OP_UNSIGNED_PRODUCT: begin
				wsz    = EAI_SZ_LONG;
				fsz    = EAI_SZ_LONG;
				res    = (c.op == EAI_OP_SIGNED_PRODUCT) ? 32'($signed(sx16(dst_val[15:0])) *
				         $signed(sx16(src[15:0]))) : {16'h0, dst_val[15:0]} * {16'h0, src[15:0]};
				wb_dst = 1'b1;
			end
			EAI_OP_SIGNED_QUOTIENT, EAI_OP_UNSIGNED_QUOTIENT: begin
				wsz    = EAI_SZ_LONG;
				fsz    = EAI_SZ_WORD;
				res    = {rem[15:0], quo[15:0]}; // remainder high, quotient low
				wb_dst = !ovf; // overflow leaves the dividend untouched
			end
			EAI_OP_MOVE_FROM_SW: begin
				wsz   = EAI_SZ_WORD;
				res   = {16'h0, sw_q};
				fl_en = 1'b0;
				wb_ea = 1'b1;
			end
			default: fl_en = 1'b0;
		endcase
		if (c.dst_kind == EAI_DST_ADDR && c.op != EAI_OP_COMPARE) fl_en = 1'b0; // address forms other than compare keep flags
		fl.n = top(fsz, res);
		fl.z = zx(fsz, res) == 32'h0;
		fl.v = 1'b0;
		fl.c = 1'b0;
		if (c.op inside {EAI_OP_SIGNED_QUOTIENT, EAI_OP_UNSIGNED_QUOTIENT}) fl.v = ovf;
		if (c.op == EAI_OP_TEST_SET) begin
			fl.n = b_op[7];
			fl.z = b_op[7:0] == 8'h0;
		end
		if (is_add) begin
			fl.c = cout(asz, addv);
			fl.v = (top(asz, a_op) == top(asz, b_op)) && (top(asz, res) != top(asz, a_op));
		end
		if (is_sub) begin
			fl.c = cout(asz, subv);
			fl.v = (top(asz, a_op) != top(asz, b_op)) && (top(asz, res) != top(asz, a_op));
		end
		if (x_en) fl.x = fl.c;
	end

	// next architectural state: bus writes first, then a launched operation
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			dreg_d[i] = dreg_q[i];
			av_d[i]   = av[i];
		end
		prog_ctr_d = prog_ctr_q;
		{msrc_d, mdst_d, ea_addr_d, ea_addr2_d} = {msrc_q, mdst_q, ea_addr_q, ea_addr2_q};
		sw_d    = sw_q;
		ext_d   = {ext0_q, ext1_q};
		ctl_d   = ctl_q;
		fault_d = fault_q;
		divz_d  = divz_q;
		if (wr) begin
			case (wb_adr_i)
				`EAI_OFF_EXT:  ext_d = bmerge(wb_sel_i, {ext0_q, ext1_q}, wb_dat_i);
				`EAI_OFF_SW:   sw_d = 16'(bmerge(wb_sel_i, {16'h0, sw_q}, wb_dat_i));
				`EAI_OFF_PROG: prog_ctr_d = bmerge(wb_sel_i, prog_ctr_q, wb_dat_i);
				`EAI_OFF_MSRC: msrc_d = bmerge(wb_sel_i, msrc_q, wb_dat_i);
				`EAI_OFF_MDST: mdst_d = bmerge(wb_sel_i, mdst_q, wb_dat_i);
				default: begin
					if (wb_adr_i[7:5] == `EAI_WIN_DATA)
						dreg_d[wb_adr_i[4:2]] = bmerge(wb_sel_i, dreg_q[wb_adr_i[4:2]], wb_dat_i);
					if (wb_adr_i[7:5] == `EAI_WIN_ADDR)
						av_d[wb_adr_i[4:2]] = bmerge(wb_sel_i, av[wb_adr_i[4:2]], wb_dat_i);
				end
			endcase
		end
		if (go) begin
			ctl_d   = c;
			fault_d = illegal;
			divz_d  = c.op inside {EAI_OP_SIGNED_QUOTIENT, EAI_OP_UNSIGNED_QUOTIENT} && src[15:0] == 16'h0;
		end
		if (go && !illegal) begin
			if (uses_ea) ea_addr_d = ea;
			if (uses_ea && c.ea_mode == 3'h3) av_d[c.ea_reg] = av[c.ea_reg] + step;
			if (uses_ea && c.ea_mode == 3'h4) av_d[c.ea_reg] = ea;
			if (pair) begin
				// second operand walks through the destination register the same way
				ea_addr2_d = (c.ea_mode == 3'h4) ? av[c.dst_reg] - stepf(c.size, c.dst_reg) : av[c.dst_reg];
				av_d[c.dst_reg] = (c.ea_mode == 3'h4) ? ea_addr2_d : av[c.dst_reg] + stepf(c.size, c.dst_reg);
			end
			if (fl_en) sw_d[4:0] = fl;
			if (wb_dst) begin
				case (c.dst_kind)
					EAI_DST_ADDR: av_d[c.dst_reg] = res;
					EAI_DST_MEM:  mdst_d = zx(wsz, res);
					default:      dreg_d[c.dst_reg] = fit(wsz, dreg_q[c.dst_reg], res);
				endcase
			end
			if (wb_ea) begin
				if (c.ea_mode == 3'h0) dreg_d[c.ea_reg] = fit(wsz, dreg_q[c.ea_reg], res);
				else mdst_d = zx(wsz, res);
			end
			case (c.op)
				EAI_OP_EXCHANGE: begin
					if (c.dst_kind == EAI_DST_ADDR) av_d[c.dst_reg] = (c.ea_mode == 3'h0) ? dreg_q[c.ea_reg] : av[c.ea_reg];
					else dreg_d[c.dst_reg] = (c.ea_mode == 3'h0) ? dreg_q[c.ea_reg] : av[c.ea_reg];
					if (c.ea_mode == 3'h0) dreg_d[c.ea_reg] = (c.dst_kind == EAI_DST_ADDR) ? av[c.dst_reg] : dreg_q[c.dst_reg];
					else av_d[c.ea_reg] = (c.dst_kind == EAI_DST_ADDR) ? av[c.dst_reg] : dreg_q[c.dst_reg];
				end
				EAI_OP_FRAME_LINK: begin
					ea_addr2_d      = act_stk - `EAI_STACK_CELL;
					mdst_d          = av[c.dst_reg];
					av_d[c.dst_reg] = ea_addr2_d;
					av_d[7]         = ea_addr2_d + sx16(ext0_q);
				end
				EAI_OP_FRAME_RELEASE: begin
					ea_addr2_d      = av[c.dst_reg]; // pop from the frame base
					av_d[7]         = av[c.dst_reg] + `EAI_STACK_CELL;
					av_d[c.dst_reg] = msrc_q;
				end
				EAI_OP_ADDRESS_LOAD: av_d[c.dst_reg] = ea;
				EAI_OP_ADDRESS_PUSH: begin
					ea_addr2_d = act_stk - `EAI_STACK_CELL;
					av_d[7]    = ea_addr2_d;
					mdst_d     = ea;
				end
				EAI_OP_IMMEDIATE_AND: sw_d = sw_q & (c.ccr_only ? {8'hff, ext0_q[7:0]} : ext0_q);
				EAI_OP_IMMEDIATE_OR:  sw_d = sw_q | (c.ccr_only ? {8'h00, ext0_q[7:0]} : ext0_q);
				EAI_OP_IMMEDIATE_XOR: sw_d = sw_q ^ (c.ccr_only ? {8'h00, ext0_q[7:0]} : ext0_q);
				EAI_OP_MOVE_TO_SW:    sw_d = c.ccr_only ? {sw_q[15:8], src[7:0]} : src[15:0];
				default: ;
			endcase
		end
	end

	// architectural registers; register seven lands in whichever stack is active
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 8; i++) dreg_q[i] <= 32'h0;
			for (int i = 0; i < 7; i++) areg_q[i] <= 32'h0;
			user_stk_q  <= 32'h0;
			super_stk_q <= 32'h0;
		end else begin
			for (int i = 0; i < 8; i++) dreg_q[i] <= dreg_d[i];
			for (int i = 0; i < 7; i++) areg_q[i] <= av_d[i];
			user_stk_q  <= (wr && wb_adr_i == `EAI_OFF_USER_STK) ? bmerge(wb_sel_i, user_stk_q, wb_dat_i) :
			               (sw_q[`EAI_SW_S] ? user_stk_q : av_d[7]);
			super_stk_q <= (wr && wb_adr_i == `EAI_OFF_SUPER_STK) ? bmerge(wb_sel_i, super_stk_q, wb_dat_i) :
			               (sw_q[`EAI_SW_S] ? av_d[7] : super_stk_q);
		end
	end

	// status word, staging registers and launch record
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_q       <= `EAI_SW_RESET;
			{ext0_q, ext1_q} <= 32'h0;
			{prog_ctr_q, msrc_q, mdst_q} <= 96'h0;
			{ea_addr_q, ea_addr2_q} <= 64'h0;
			ctl_q      <= '0;
			fault_q    <= 1'b0;
			divz_q     <= 1'b0;
		end else begin
			sw_q       <= sw_d;
			{ext0_q, ext1_q} <= ext_d;
			{prog_ctr_q, msrc_q, mdst_q} <= {prog_ctr_d, msrc_d, mdst_d};
			{ea_addr_q, ea_addr2_q} <= {ea_addr_d, ea_addr2_d};
			ctl_q      <= ctl_d;
			fault_q    <= fault_d;
			divz_q     <= divz_d;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdat = 32'h0;
		case (wb_adr_i)
			`EAI_OFF_CTRL:      rdat = ctl_q;
			`EAI_OFF_EXT:       rdat = {ext0_q, ext1_q};
			`EAI_OFF_SW:        rdat = {16'h0, sw_q};
			`EAI_OFF_PROG:      rdat = prog_ctr_q;
			`EAI_OFF_MSRC:      rdat = msrc_q;
			`EAI_OFF_MDST:      rdat = mdst_q;
			`EAI_OFF_EA_ADDR:   rdat = ea_addr_q;
			`EAI_OFF_EA_ADDR2:  rdat = ea_addr2_q;
			`EAI_OFF_STAT:      rdat = {30'h0, divz_q, fault_q};
			`EAI_OFF_USER_STK:  rdat = user_stk_q;
			`EAI_OFF_SUPER_STK: rdat = super_stk_q;
			default: begin
				if (wb_adr_i[7:5] == `EAI_WIN_DATA) rdat = dreg_q[wb_adr_i[4:2]];
				if (wb_adr_i[7:5] == `EAI_WIN_ADDR) rdat = av[wb_adr_i[4:2]];
			end
		endcase
	end

	// single-wait answer: ack one cycle after the strobe, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q  <= req;
			rdat_q <= (req && !wb_we_i) ? rdat : rdat_q;
		end
	end
endmodule : eai_exec_unit
`default_nettype wire

// file: tb/eai_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module eai_mem_model (
	// operand bus
	input  wire logic [31:0] addr_i,
	output logic      [31:0] data_o
);
	// word carries its own address, so a misrouted read shows
	assign data_o = {addr_i[15:0], ~addr_i[15:0]};
endmodule : eai_mem_model
`default_nettype wire

// file: tb/eai_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module eai_chk (
	// clock, reset and bus
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [7:0]            wb_adr_i,
	input wire logic [3:0]            wb_sel_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic                  wb_ack_o,
	// core state
	input wire logic                  supervisor_o,
	input wire logic                  fault_o,
	input wire eai_pkg::eai_flags_type flags_o
);
	import eai_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic       go;
	logic [5:0] op;
	// launches only count on full-width writes not yet answered
	assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hf;
	assign op = wb_dat_i[5:0];
	sequence s_ctl; go && wb_adr_i == 8'h00; endsequence
	sequence s_sw; go && wb_adr_i == 8'h08; endsequence
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	property p_sup_off; s_sw ##0 !wb_dat_i[13] |=> !supervisor_o; endproperty
	property p_unassigned; s_ctl ##0 (op == 6'h00 && wb_dat_i[13:11] == 3'h7 && wb_dat_i[10:8] > 3'h4) |=> fault_o; endproperty
	property p_an_byte; s_ctl ##0 (op == 6'h00 && wb_dat_i[18:17] == 2'h1 && wb_dat_i[7:6] == 2'h0) |=> fault_o; endproperty
	property p_add_byte; s_ctl ##0 ((op == 6'h08 || op == 6'h09) && wb_dat_i[18:17] == 2'h1 && wb_dat_i[7:6] == 2'h0) |=> fault_o; endproperty
	property p_sw_only; s_ctl ##0 (wb_dat_i[19] && op < 6'h17) |=> fault_o; endproperty
	property p_an_ok; s_ctl ##0 (op == 6'h00 && wb_dat_i[20:17] == 4'h1 && wb_dat_i[13:6] == 8'h01) |=> !fault_o && $stable(flags_o); endproperty
	property p_quick; s_ctl ##0 (op == 6'h05 && wb_dat_i[20:17] == 4'h0) |=> !fault_o; endproperty
	a_ack: assert property (p_ack) else $error("ack not a one-cycle answer");
	a_sup_off: assert property (p_sup_off) else $error("supervisor still set");
	a_unassigned: assert property (p_unassigned) else $error("unassigned mode taken");
	a_an_byte: assert property (p_an_byte) else $error("byte move to address taken");
	a_add_byte: assert property (p_add_byte) else $error("byte add to address taken");
	a_sw_only: assert property (p_sw_only) else $error("status word op taken");
	a_an_ok: assert property (p_an_ok) else $error("address move faulted or flagged");
	a_quick: assert property (p_quick) else $error("quick load refused");
endmodule : eai_chk
bind eai_exec_unit eai_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.supervisor_o(supervisor_o), .fault_o(fault_o), .flags_o(flags_o));
`default_nettype wire

// file: tb/ea_decode_integer_ops_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ea_decode_integer_ops_bench;
	import eai_pkg::*;
	logic          clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, sup, flt;
	logic [7:0]    adr = 8'h00;
	logic [3:0]    sel = 4'h0;
	logic [31:0]   wdat = 32'h0, dat_o, rd, mdat;
	eai_flags_type flg;
	int            n_fail = 0, comparisons = 0, ticks = 0;
	// clock and hang guard
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		ticks++;
		if (ticks == 3000) begin
			n_fail++;
			wrap_up();
		end
	end
	eai_mem_model mem (.addr_i(32'h100), .data_o(mdat));
	eai_exec_unit uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.supervisor_o(sup), .fault_o(flt), .flags_o(flg));
	// one classic cycle, held until ack is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, we, adr, wdat, sel} <= {1'b1, w, a, d, 4'hf};
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rd = dat_o;
		{cyc, we} <= 2'b00;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rchk
	function automatic logic [31:0] ctl(eai_op_type o, eai_size_type z, logic [2:0] m, logic [2:0] r,
		logic [1:0] k, logic [2:0] d);
		return {13'h0, k, d, m, r, z, o};
	endfunction : ctl
	// a clean quick load first, so a stale fault cannot pass for a new one
	task automatic refuse(input logic [31:0] w);
		wr(8'h00, ctl(EAI_OP_QUICK_LOAD, EAI_SZ_BYTE, 3'h0, 3'h0, 2'h0, 3'h0));
		rchk(8'h20, 32'h0, "stat");
		wr(8'h00, w);
		rchk(8'h20, 32'h1, "stat");
		chk("fault", 32'h1, {31'h0, flt});
	endtask : refuse
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	// main sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(8'h08, 32'h2000, "sw");
		wr(8'h04, 32'h9abc_1234);
		for (int i = 0; i < 3; i++) wr(8'h00, ctl(EAI_OP_MOVE, eai_size_type'(i), 3'h7, 3'h4, 2'h0, 3'(i + 1)));
		rchk(8'h44, 32'hbc, "d1");
		rchk(8'h48, 32'h9abc, "d2");
		rchk(8'h4c, 32'h9abc_1234, "d3");
		wr(8'h00, ctl(EAI_OP_SWAP, EAI_SZ_LONG, 3'h0, 3'h3, 2'h0, 3'h3));
		rchk(8'h4c, 32'h1234_9abc, "swap");
		wr(8'h64, 32'h100);
		wr(8'h10, mdat);
		wr(8'h00, ctl(EAI_OP_MOVE, EAI_SZ_LONG, 3'h3, 3'h1, 2'h0, 3'h2));
		rchk(8'h48, 32'h0100_feff, "mem");
		rchk(8'h64, 32'h104, "a1");
		rchk(8'h18, 32'h100, "ea");
		wr(8'h50, 32'hffff_0003);
		wr(8'h54, 32'h0001_0005);
		wr(8'h00, ctl(EAI_OP_UNSIGNED_PRODUCT, EAI_SZ_WORD, 3'h0, 3'h4, 2'h0, 3'h5));
		rchk(8'h54, 32'hf, "mul");
		wr(8'h58, 32'h64);
		wr(8'h5c, 32'h7);
		wr(8'h00, ctl(EAI_OP_UNSIGNED_QUOTIENT, EAI_SZ_WORD, 3'h0, 3'h7, 2'h0, 3'h6));
		rchk(8'h58, 32'h0002_000e, "div");
		wr(8'h08, 32'h2010);
		wr(8'h40, 32'h1);
		wr(8'h00, ctl(EAI_OP_EXTENDED_SUM, EAI_SZ_BYTE, 3'h0, 3'h0, 2'h0, 3'h1));
		rchk(8'h44, 32'hbe, "xsum");
		chk("xsum flags", 32'h8, {27'h0, flg});
		wr(8'h00, ctl(EAI_OP_TEST_SET, EAI_SZ_BYTE, 3'h0, 3'h7, 2'h0, 3'h7));
		rchk(8'h5c, 32'h87, "tas");
		wr(8'h04, 32'h0042_0000);
		refuse(ctl(EAI_OP_MOVE, EAI_SZ_BYTE, 3'h0, 3'h0, 2'h1, 3'h2));
		refuse(ctl(EAI_OP_ADD, EAI_SZ_BYTE, 3'h0, 3'h0, 2'h1, 3'h2));
		refuse(ctl(EAI_OP_SWAP, EAI_SZ_LONG, 3'h0, 3'h0, 2'h0, 3'h0) | 32'h8_0000);
		refuse(ctl(EAI_OP_MOVE, EAI_SZ_WORD, 3'h7, 3'h5, 2'h0, 3'h0));
		rchk(8'h40, 32'h42, "quick");
		wr(8'h00, ctl(EAI_OP_MOVE, EAI_SZ_WORD, 3'h0, 3'h0, 2'h1, 3'h2));
		rchk(8'h68, 32'h42, "a2");
		wr(8'h24, 32'h2000);
		wr(8'h28, 32'h1000);
		rchk(8'h7c, 32'h1000, "ssp");
		wr(8'h08, 32'h0);
		rchk(8'h7c, 32'h2000, "usp");
		chk("sup", 32'h0, {31'h0, sup});
		// frame link and release on the user stack, then stepping through the stack register
		wr(8'h04, 32'hfff8_0000);
		wr(8'h00, ctl(EAI_OP_FRAME_LINK, EAI_SZ_LONG, 3'h0, 3'h0, 2'h0, 3'h2));
		rchk(8'h14, 32'h42, "link push");
		rchk(8'h68, 32'h1ffc, "link frame");
		rchk(8'h24, 32'h1ff4, "link sp");
		wr(8'h10, 32'h77);
		wr(8'h00, ctl(EAI_OP_FRAME_RELEASE, EAI_SZ_LONG, 3'h0, 3'h0, 2'h0, 3'h2));
		rchk(8'h7c, 32'h2000, "release sp");
		rchk(8'h68, 32'h77, "release reg");
		wr(8'h00, ctl(EAI_OP_ADDRESS_LOAD, EAI_SZ_LONG, 3'h5, 3'h2, 2'h0, 3'h3));
		rchk(8'h6c, 32'h6f, "address load");
		wr(8'h00, ctl(EAI_OP_MOVE, EAI_SZ_BYTE, 3'h4, 3'h7, 2'h0, 3'h4));
		rchk(8'h7c, 32'h1ffe, "byte predec");
		rchk(8'h18, 32'h1ffe, "predec ea");
		// single-operand forms and flag-only forms
		wr(8'h00, ctl(EAI_OP_NEGATE, EAI_SZ_WORD, 3'h0, 3'h4, 2'h0, 3'h0));
		rchk(8'h50, 32'hffff_ff89, "negate");
		chk("negate flags", 32'h19, {27'h0, flg});
		wr(8'h00, ctl(EAI_OP_SIGN_WIDEN, EAI_SZ_LONG, 3'h0, 3'h0, 2'h0, 3'h3));
		rchk(8'h4c, 32'hffff_9abc, "widen");
		wr(8'h00, ctl(EAI_OP_ZERO_WRITE, EAI_SZ_BYTE, 3'h0, 3'h0, 2'h0, 3'h0));
		rchk(8'h40, 32'h0, "zero write");
		wr(8'h00, ctl(EAI_OP_ZERO_TEST, EAI_SZ_LONG, 3'h0, 3'h3, 2'h0, 3'h0));
		chk("test flags", 32'h18, {27'h0, flg});
		rchk(8'h4c, 32'hffff_9abc, "tested");
		wr(8'h00, ctl(EAI_OP_COMPARE, EAI_SZ_LONG, 3'h0, 3'h1, 2'h0, 3'h1));
		chk("compare flags", 32'h14, {27'h0, flg});
		rchk(8'h44, 32'hbe, "compared");
		wrap_up();
	end
endmodule : ea_decode_integer_ops_bench
`default_nettype wire
